// [logic/amode_decoder.sv]
// addressing-mode decoder: classifies, fetches operands and pointers, forms addresses
`timescale 1ns/1ns
module amode_decoder
    import amode_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // instruction byte stream
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_DATA,
    input wire logic [amode_pkg::ADDR_W-1:0] FETCH_PC,
    output logic BYTE_READY,
    // index registers
    input wire logic [7:0] X_REG,
    input wire logic [7:0] Y_REG,
    // page-zero pointer reads
    output logic MEM_REQ,
    output logic [amode_pkg::ADDR_W-1:0] MEM_ADDR,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_ACK,
    // decoded result
    output logic DEC_VALID,
    output amode_pkg::amode_t MODE,
    output amode_pkg::mclass_t MODE_CLASS,
    output amode_pkg::inh_op_t INH_OP,
    output logic [7:0] OPCODE,
    output logic [amode_pkg::LEN_W-1:0] LENGTH,
    output logic USE_Y,
    output logic RMW,
    output logic LONG_FORM,
    output logic ILLEGAL,
    output logic [7:0] OPERAND,
    output logic [2:0] BIT_NUM,
    output logic [amode_pkg::ADDR_W-1:0] EFF_ADDR,
    output logic [amode_pkg::ADDR_W-1:0] JUMP_TARGET
);
    import amode_pkg::*;

    typedef enum logic [2:0] {S_FETCH, S_OPER, S_PTR0, S_PTR1, S_EMIT} state_t;

    state_t state, next_state;
    logic have_prefix, next_have_prefix;
    logic [7:0] prefix, next_prefix;
    logic [7:0] opcode, next_opcode;
    amode_t mode, next_mode;
    logic use_y, next_use_y;
    logic illegal, next_illegal;
    logic [1:0] need, next_need;
    logic [1:0] got, next_got;
    logic [7:0] first, next_first;
    logic [7:0] second, next_second;
    logic [ADDR_W-1:0] pointer, next_pointer;
    logic [ADDR_W-1:0] start_pc, next_start_pc;
    logic [LEN_W-1:0] len, next_len;
    logic byte_ready, next_byte_ready;
    logic mem_req, next_mem_req;
    logic [ADDR_W-1:0] mem_addr, next_mem_addr;
    logic dec_valid, next_dec_valid;
    logic [ADDR_W-1:0] ea;
    logic [7:0] rel_offset;
    logic [ADDR_W-1:0] target;
    amode_t dmode;
    logic dy, dill;
    inh_op_t inh;

    // opcode column plus prefix to mode
    always_comb begin
        dy = (prefix == Y_REGISTER_PREFIX || prefix == Y_INDIRECT_PREFIX) && have_prefix;
        dill = 1'b0;
        unique case (BYTE_DATA[7:4])
            COL_BIT_REL: dmode = M_BIT_DIR_REL;
            COL_BIT: dmode = M_BIT_DIRECT;
            COL_REL: dmode = M_REL_DIRECT;
            COL_RMW_DIR, COL_DIR: dmode = M_DIR_SHORT;
            COL_EXT: dmode = M_DIR_LONG;
            COL_RMW_IDX, COL_IDX: dmode = M_IDX_SHORT;
            COL_RMW_IDX0, COL_IDX0: dmode = M_IDX_NONE;
            COL_IDX_LONG: dmode = M_IDX_LONG;
            COL_IMM: dmode = M_IMMEDIATE;
            default: dmode = M_INHERENT;
        endcase
        if (have_prefix && prefix != Y_REGISTER_PREFIX) begin
            unique case (dmode)
                M_DIR_SHORT: dmode = M_IND_SHORT;
                M_DIR_LONG: dmode = M_IND_LONG;
                M_IDX_SHORT: dmode = M_IND_IDX_SHORT;
                M_IDX_LONG: dmode = M_IND_IDX_LONG;
                M_REL_DIRECT: dmode = M_REL_INDIRECT;
                M_BIT_DIRECT: dmode = M_BIT_INDIRECT;
                M_BIT_DIR_REL: dmode = M_BIT_IND_REL;
                default: dill = 1'b1;
            endcase
            if (prefix == Y_INDIRECT_PREFIX && mode_class(dmode) != C_INDIRECT) begin
                dill = 1'b1;
            end
            if (prefix == Y_INDIRECT_PREFIX && (dmode == M_IND_SHORT || dmode == M_IND_LONG)) begin
                dill = 1'b1;
            end
        end
        if (dy && (mode_class(dmode) == C_RELATIVE || mode_class(dmode) == C_BIT)) begin
            dill = 1'b1;
        end
    end

    // named inherent operations
    always_comb begin
        inh = I_NONE;
        if (mode == M_INHERENT) begin
            inh = I_REG_ALU;
            unique case (opcode)
                NOP_OP: inh = I_NOP;
                TRAP_OP: inh = I_TRAP;
                WAIT_FOR_IRQ_OP: inh = I_WAIT;
                HALT_OP: inh = I_HALT;
                RETURN_OP: inh = I_RET;
                INTERRUPT_RETURN_OP: inh = I_INTERRUPT_RETURN_OP;
                PUSH_A_OP, PUSH_X_OP: inh = I_PUSH;
                POP_A_OP, POP_X_OP: inh = I_POP;
                STACK_POINTER_RESET_OP: inh = I_SP_RESET;
                SET_IRQ_MASK_OP: inh = I_SET_MASK;
                CLEAR_IRQ_MASK_OP: inh = I_CLR_MASK;
                SET_CARRY_OP: inh = I_SET_CARRY;
                CLEAR_CARRY_OP: inh = I_CLR_CARRY;
                BYTE_MULTIPLY_OP: inh = I_MUL;
                default: inh = I_REG_ALU;
            endcase
        end
    end

    ea_former u_ea (
        .mode(mode),
        .first(first),
        .second(second),
        .pointer(pointer),
        .index(use_y ? Y_REG : X_REG),
        .ea(ea)
    );

    // relative target from the following instruction's address
    always_comb begin
        unique case (mode)
            M_REL_DIRECT: rel_offset = first;
            M_REL_INDIRECT: rel_offset = pointer[7:0];
            default: rel_offset = second;
        endcase
        target = start_pc + {{(ADDR_W-LEN_W){1'b0}}, len}
                 + {{(ADDR_W-8){rel_offset[7]}}, rel_offset};
    end

    // sequencing
    always_comb begin
        next_state = state;
        next_have_prefix = have_prefix;
        next_prefix = prefix;
        next_opcode = opcode;
        next_mode = mode;
        next_use_y = use_y;
        next_illegal = illegal;
        next_need = need;
        next_got = got;
        next_first = first;
        next_second = second;
        next_pointer = pointer;
        next_start_pc = start_pc;
        next_len = len;
        next_mem_addr = mem_addr;
        next_dec_valid = 1'b0;
        unique case (state)
            S_FETCH: begin
                if (BYTE_VALID && byte_ready) begin
                    next_len = len + LEN_W'(1);
                    if (!have_prefix) begin
                        next_start_pc = FETCH_PC;
                    end
                    if (!have_prefix && (BYTE_DATA == Y_REGISTER_PREFIX
                        || BYTE_DATA == INDIRECT_PREFIX || BYTE_DATA == Y_INDIRECT_PREFIX)) begin
                        next_have_prefix = 1'b1;
                        next_prefix = BYTE_DATA;
                    end else begin
                        next_opcode = BYTE_DATA;
                        next_mode = dmode;
                        next_use_y = dy;
                        next_illegal = dill;
                        next_need = operand_count(dmode);
                        next_got = 2'd0;
                        next_state = (operand_count(dmode) == 2'd0) ? S_EMIT : S_OPER;
                    end
                end
            end
            S_OPER: begin
                if (BYTE_VALID && byte_ready) begin
                    next_len = len + LEN_W'(1);
                    next_got = got + 2'd1;
                    if (got == 2'd0) begin
                        next_first = BYTE_DATA;
                    end else begin
                        next_second = BYTE_DATA;
                    end
                    if (got + 2'd1 == need) begin
                        if (ptr_size(mode) == P_NONE) begin
                            next_state = S_EMIT;
                        end else begin
                            next_state = S_PTR0;
                            next_mem_addr = {PAGE_ZERO, got == 2'd0 ? BYTE_DATA : first};
                        end
                    end
                end
            end
            S_PTR0: begin
                if (MEM_ACK) begin
                    if (ptr_size(mode) == P_WORD) begin
                        next_pointer = {MEM_RDATA, PAGE_ZERO};
                        next_mem_addr = {PAGE_ZERO, mem_addr[7:0] + 8'h01};
                        next_state = S_PTR1;
                    end else begin
                        next_pointer = {PAGE_ZERO, MEM_RDATA};
                        next_state = S_EMIT;
                    end
                end
            end
            S_PTR1: begin
                if (MEM_ACK) begin
                    next_pointer = {pointer[ADDR_W-1:8], MEM_RDATA};
                    next_state = S_EMIT;
                end
            end
            S_EMIT: begin
                next_dec_valid = 1'b1;
                next_have_prefix = 1'b0;
                next_len = '0;
                next_state = S_FETCH;
            end
            default: next_state = S_FETCH;
        endcase
        next_byte_ready = (next_state == S_FETCH || next_state == S_OPER);
        next_mem_req = (next_state == S_PTR0 || next_state == S_PTR1);
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state <= S_FETCH;
            have_prefix <= 1'b0;
            prefix <= '0;
            opcode <= '0;
            mode <= M_INHERENT;
            use_y <= 1'b0;
            illegal <= 1'b0;
            need <= '0;
            got <= '0;
            first <= '0;
            second <= '0;
            pointer <= '0;
            start_pc <= '0;
            len <= '0;
            byte_ready <= 1'b0;
            mem_req <= 1'b0;
            mem_addr <= '0;
            dec_valid <= 1'b0;
        end else begin
            state <= next_state;
            have_prefix <= next_have_prefix;
            prefix <= next_prefix;
            opcode <= next_opcode;
            mode <= next_mode;
            use_y <= next_use_y;
            illegal <= next_illegal;
            need <= next_need;
            got <= next_got;
            first <= next_first;
            second <= next_second;
            pointer <= next_pointer;
            start_pc <= next_start_pc;
            len <= next_len;
            byte_ready <= next_byte_ready;
            mem_req <= next_mem_req;
            mem_addr <= next_mem_addr;
            dec_valid <= next_dec_valid;
        end
    end

    // result registers, loaded in the emit cycle
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            MODE <= M_INHERENT;
            MODE_CLASS <= C_INHERENT;
            INH_OP <= I_NONE;
            OPCODE <= '0;
            LENGTH <= '0;
            USE_Y <= 1'b0;
            RMW <= 1'b0;
            LONG_FORM <= 1'b0;
            ILLEGAL <= 1'b0;
            OPERAND <= '0;
            BIT_NUM <= '0;
            EFF_ADDR <= '0;
            JUMP_TARGET <= '0;
        end else if (state == S_EMIT) begin
            MODE <= mode;
            MODE_CLASS <= mode_class(mode);
            INH_OP <= inh;
            OPCODE <= opcode;
            LENGTH <= len;
            USE_Y <= use_y;
            RMW <= opcode[7:4] == COL_BIT_REL || opcode[7:4] == COL_BIT
                   || opcode[7:4] == COL_RMW_DIR || opcode[7:4] == COL_RMW_IDX
                   || opcode[7:4] == COL_RMW_IDX0;
            LONG_FORM <= mode == M_DIR_LONG || mode == M_IDX_LONG
                         || mode == M_IND_LONG || mode == M_IND_IDX_LONG;
            ILLEGAL <= illegal;
            OPERAND <= first;
            BIT_NUM <= opcode[BIT_MSB:BIT_LSB];
            EFF_ADDR <= ea;
            JUMP_TARGET <= target;
        end
    end

    assign BYTE_READY = byte_ready;
    assign MEM_REQ = mem_req;
    assign MEM_ADDR = mem_addr;
    assign DEC_VALID = dec_valid;
endmodule : amode_decoder

// [logic/amode_pkg.sv]
// constants, types and helpers for the addressing-mode decoder
// Operation
// - seventeen addressing modes sorted into seven classes
// - long variants reach the whole 64 Kbyte space using extra bytes
// - short variants other than indexed reach page zero, 0000h to 00FFh, with fewer bytes
// - read-modify-write memory operations exist only in short forms
// - inherent instructions are one opcode byte, nothing fetched after it
// - immediate instructions are opcode plus one literal byte
// - direct mode takes one address byte short, two bytes long
// - relative targets add offset to address of following instruction
// - inherent set holds no-op, trap and wait-for-interrupt
// - inherent set holds halt, which stops the oscillator
// - inherent set holds stack, mask, carry, return, multiply, shift ops
// - indexed address is unsigned X or Y plus none, byte or word offset
// - short indexed reaches 00 to 1FE
// - prefixes 90, 92, 91 select Y, indirect, Y indirect indexed
// - relative offset is signed 8-bit, from stream or from memory
package amode_pkg;
    localparam int ADDR_W = 16;
    localparam int LEN_W = 3;

    typedef enum logic [4:0] {
        M_INHERENT, M_IMMEDIATE, M_DIR_SHORT, M_DIR_LONG,
        M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG,
        M_IND_SHORT, M_IND_LONG, M_IND_IDX_SHORT, M_IND_IDX_LONG,
        M_REL_DIRECT, M_REL_INDIRECT,
        M_BIT_DIRECT, M_BIT_INDIRECT, M_BIT_DIR_REL, M_BIT_IND_REL
    } amode_t;

    typedef enum logic [2:0] {
        C_INHERENT, C_IMMEDIATE, C_DIRECT, C_INDEXED, C_INDIRECT, C_RELATIVE, C_BIT
    } mclass_t;

    typedef enum logic [3:0] {
        I_NONE, I_NOP, I_TRAP, I_WAIT, I_HALT, I_RET, I_INTERRUPT_RETURN_OP, I_PUSH, I_POP,
        I_SP_RESET, I_SET_MASK, I_CLR_MASK, I_SET_CARRY, I_CLR_CARRY, I_MUL, I_REG_ALU
    } inh_op_t;

    typedef enum logic [1:0] {P_NONE, P_BYTE, P_WORD} ptr_size_t;

    // prefix bytes
    localparam logic [7:0] Y_REGISTER_PREFIX = 8'h90;
    localparam logic [7:0] INDIRECT_PREFIX = 8'h92;
    localparam logic [7:0] Y_INDIRECT_PREFIX = 8'h91;

    // inherent opcodes
    localparam logic [7:0] NOP_OP = 8'h9d;
    localparam logic [7:0] TRAP_OP = 8'h83;
    localparam logic [7:0] WAIT_FOR_IRQ_OP = 8'h8f;
    localparam logic [7:0] HALT_OP = 8'h8e;
    localparam logic [7:0] RETURN_OP = 8'h81;
    localparam logic [7:0] INTERRUPT_RETURN_OP = 8'h80;
    localparam logic [7:0] SET_IRQ_MASK_OP = 8'h9b;
    localparam logic [7:0] CLEAR_IRQ_MASK_OP = 8'h9a;
    localparam logic [7:0] SET_CARRY_OP = 8'h99;
    localparam logic [7:0] CLEAR_CARRY_OP = 8'h98;
    localparam logic [7:0] STACK_POINTER_RESET_OP = 8'h9c;
    localparam logic [7:0] BYTE_MULTIPLY_OP = 8'h42;
    localparam logic [7:0] POP_A_OP = 8'h84;
    localparam logic [7:0] POP_X_OP = 8'h85;
    localparam logic [7:0] PUSH_A_OP = 8'h88;
    localparam logic [7:0] PUSH_X_OP = 8'h89;

    // opcode columns (high nibble)
    localparam logic [3:0] COL_BIT_REL = 4'h0;
    localparam logic [3:0] COL_BIT = 4'h1;
    localparam logic [3:0] COL_REL = 4'h2;
    localparam logic [3:0] COL_RMW_DIR = 4'h3;
    localparam logic [3:0] COL_INH_A = 4'h4;
    localparam logic [3:0] COL_INH_X = 4'h5;
    localparam logic [3:0] COL_RMW_IDX = 4'h6;
    localparam logic [3:0] COL_RMW_IDX0 = 4'h7;
    localparam logic [3:0] COL_INH_8 = 4'h8;
    localparam logic [3:0] COL_INH_9 = 4'h9;
    localparam logic [3:0] COL_IMM = 4'ha;
    localparam logic [3:0] COL_DIR = 4'hb;
    localparam logic [3:0] COL_EXT = 4'hc;
    localparam logic [3:0] COL_IDX_LONG = 4'hd;
    localparam logic [3:0] COL_IDX = 4'he;
    localparam logic [3:0] COL_IDX0 = 4'hf;

    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam int BIT_LSB = 1;
    localparam int BIT_MSB = 3;

    function automatic logic [1:0] operand_count(input amode_t m);
        unique case (m)
            M_INHERENT, M_IDX_NONE: operand_count = 2'd0;
            M_DIR_LONG, M_IDX_LONG, M_BIT_DIR_REL, M_BIT_IND_REL: operand_count = 2'd2;
            default: operand_count = 2'd1;
        endcase
    endfunction : operand_count

    function automatic ptr_size_t ptr_size(input amode_t m);
        unique case (m)
            M_IND_LONG, M_IND_IDX_LONG: ptr_size = P_WORD;
            M_IND_SHORT, M_IND_IDX_SHORT, M_REL_INDIRECT, M_BIT_INDIRECT,
            M_BIT_IND_REL: ptr_size = P_BYTE;
            default: ptr_size = P_NONE;
        endcase
    endfunction : ptr_size

    function automatic mclass_t mode_class(input amode_t m);
        unique case (m)
            M_INHERENT: mode_class = C_INHERENT;
            M_IMMEDIATE: mode_class = C_IMMEDIATE;
            M_DIR_SHORT, M_DIR_LONG: mode_class = C_DIRECT;
            M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG: mode_class = C_INDEXED;
            M_REL_DIRECT, M_REL_INDIRECT: mode_class = C_RELATIVE;
            M_BIT_DIRECT, M_BIT_INDIRECT, M_BIT_DIR_REL, M_BIT_IND_REL: mode_class = C_BIT;
            default: mode_class = C_INDIRECT;
        endcase
    endfunction : mode_class

    // unsigned base plus index, full 16-bit result
    function automatic logic [ADDR_W-1:0] add_index(input logic [ADDR_W-1:0] base,
                                                   input logic [7:0] idx);
        add_index = base + {PAGE_ZERO, idx};
    endfunction : add_index
endpackage : amode_pkg

// [logic/ea_former.sv]
// effective address formation from operand bytes, pointer and index
`timescale 1ns/1ns
module ea_former
    import amode_pkg::*;
(
    input amode_t mode,
    input logic [7:0] first,
    input logic [7:0] second,
    input logic [ADDR_W-1:0] pointer,
    input logic [7:0] index,
    output logic [ADDR_W-1:0] ea
);
    always_comb begin
        unique case (mode)
            M_DIR_SHORT, M_BIT_DIRECT, M_BIT_DIR_REL: ea = {PAGE_ZERO, first};
            M_DIR_LONG: ea = {first, second};
            M_IDX_NONE: ea = {PAGE_ZERO, index};
            M_IDX_SHORT: ea = add_index({PAGE_ZERO, first}, index);
            M_IDX_LONG: ea = add_index({first, second}, index);
            M_IND_SHORT, M_IND_LONG, M_BIT_INDIRECT, M_BIT_IND_REL: ea = pointer;
            M_IND_IDX_SHORT, M_IND_IDX_LONG: ea = add_index(pointer, index);
            default: ea = '0;
        endcase
    end
endmodule : ea_former

// [verif/amode_decoder_properties.sv]
// port checks for the addressing-mode decoder
`timescale 1ns/1ns
module amode_decoder_properties
    import amode_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic BYTE_READY,
    input wire logic MEM_REQ,
    input wire logic [amode_pkg::ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire logic DEC_VALID,
    input amode_pkg::amode_t MODE,
    input amode_pkg::mclass_t MODE_CLASS,
    input wire logic [amode_pkg::LEN_W-1:0] LENGTH,
    input wire logic USE_Y,
    input wire logic RMW,
    input wire logic LONG_FORM,
    input wire logic ILLEGAL,
    input wire logic [amode_pkg::ADDR_W-1:0] EFF_ADDR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    a_valid_pulse: assert property (DEC_VALID |=> !DEC_VALID)
        else $error("result strobe too wide");
    a_ptr_page_zero: assert property (MEM_REQ |-> MEM_ADDR[15:8] == 8'h00)
        else $error("pointer off page zero");
    a_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("pointer request dropped");
    a_no_fetch_ptr: assert property (MEM_REQ |-> !BYTE_READY)
        else $error("stream open in pointer read");
    a_emit_after_ptr: assert property ($fell(MEM_REQ) |-> ##1 DEC_VALID)
        else $error("no result after pointer read");
    a_ready_gap: assert property (DEC_VALID |-> !$past(BYTE_READY))
        else $error("stream open before result");
    a_inh_one_byte: assert property (DEC_VALID && MODE == M_INHERENT && !USE_Y && !ILLEGAL
        |-> LENGTH == 3'h1)
        else $error("inherent length wrong");
    a_long_direct: assert property (DEC_VALID && MODE == M_DIR_LONG && !USE_Y && !ILLEGAL
        |-> MODE_CLASS == C_DIRECT && LONG_FORM && LENGTH == 3'h3)
        else $error("long direct decode wrong");
    a_short_page: assert property (DEC_VALID && MODE inside {M_DIR_SHORT, M_IND_SHORT,
        M_BIT_DIRECT, M_BIT_INDIRECT} |-> EFF_ADDR[15:8] == 8'h00)
        else $error("short address off page zero");
    a_idx_short_range: assert property (DEC_VALID && MODE inside {M_IDX_NONE, M_IDX_SHORT,
        M_IND_IDX_SHORT} |-> EFF_ADDR <= 16'h01fe)
        else $error("short index too high");
    a_rmw_short: assert property (DEC_VALID && RMW && !ILLEGAL |-> !LONG_FORM)
        else $error("long form on read-modify-write");
    cover property (DEC_VALID && MODE == M_IND_LONG);
    cover property (DEC_VALID && MODE == M_BIT_IND_REL);
    cover property (MEM_REQ && MEM_ACK);
    cover property (DEC_VALID && ILLEGAL);
endmodule : amode_decoder_properties

bind amode_decoder amode_decoder_properties i_amode_decoder_properties (.*);

// [verif/mem_model.sv]
// page-zero memory answering pointer reads after a set wait
`timescale 1ns/1ns
module mem_model (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // pointer port
    input wire logic req,
    input wire logic [15:0] addr,
    input wire logic [1:0] lat,
    output logic ack,
    output logic [7:0] rdata
);
    logic [1:0] cnt = 2'h0;
    initial ack = 1'b0;
    initial rdata = 8'h3c;
    always @(posedge clock) begin
        if (srst || !req || ack) begin
            ack <= 1'b0;
            cnt <= 2'h0;
            rdata <= ~rdata;
        end else if (cnt >= lat) begin
            ack <= 1'b1;
            rdata <= addr[7:0] ^ 8'ha5;
        end else begin
            cnt <= cnt + 2'h1;
            rdata <= ~rdata;
        end
    end
endmodule : mem_model

// [verif/cpu_addressing_mode_decoder_bench.sv]
// self-checking bench for the addressing-mode decoder
`timescale 1ns/1ns
module cpu_addressing_mode_decoder_bench;
    import amode_pkg::*;
    typedef struct {
        amode_t m; logic [2:0] len; logic [15:0] ea; logic [15:0] jt;
        logic [2:0] fl; inh_op_t inh; logic [7:0] op; logic [7:0] opnd;
    } exp_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic byte_valid = 1'b0;
    logic [7:0] byte_data = '0;
    logic [15:0] fetch_pc = '0;
    logic [7:0] x_reg = '0;
    logic [7:0] y_reg = '0;
    logic [1:0] lat = '0;
    logic byte_ready, mem_req, mem_ack, dec_valid, use_y, rmw, long_form, illegal;
    logic [15:0] mem_addr, eff_addr, jump_target;
    logic [7:0] mem_rdata, opcode, operand;
    logic [2:0] length, bit_num;
    amode_t mode;
    mclass_t mode_class;
    inh_op_t inh_op;
    exp_t q[$];
    int errors = 0;
    int cmp_count = 0;
    logic [15:0] rng = 16'hb6a1;
    logic [7:0] x, y, o, h, p;
    logic [15:0] pc;
    logic [7:0] iops [15] = '{8'h9d, 8'h83, 8'h8f, 8'h8e, 8'h81, 8'h80, 8'h9b, 8'h9a,
        8'h99, 8'h98, 8'h9c, 8'h42, 8'h84, 8'h88, 8'h4c};
    inh_op_t iexp [15] = '{I_NOP, I_TRAP, I_WAIT, I_HALT, I_RET, I_INTERRUPT_RETURN_OP, I_SET_MASK,
        I_CLR_MASK, I_SET_CARRY, I_CLR_CARRY, I_SP_RESET, I_MUL, I_POP, I_PUSH, I_REG_ALU};

    amode_decoder i_amode_decoder (.CLOCK(clock), .SRST(srst), .BYTE_VALID(byte_valid),
        .BYTE_DATA(byte_data), .FETCH_PC(fetch_pc), .BYTE_READY(byte_ready),
        .X_REG(x_reg), .Y_REG(y_reg), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr),
        .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .DEC_VALID(dec_valid), .MODE(mode),
        .MODE_CLASS(mode_class), .INH_OP(inh_op), .OPCODE(opcode), .LENGTH(length),
        .USE_Y(use_y), .RMW(rmw), .LONG_FORM(long_form), .ILLEGAL(illegal),
        .OPERAND(operand), .BIT_NUM(bit_num), .EFF_ADDR(eff_addr),
        .JUMP_TARGET(jump_target));
    mem_model i_mem_model (.clock(clock), .srst(srst), .req(mem_req), .addr(mem_addr),
        .lat(lat), .ack(mem_ack), .rdata(mem_rdata));

    initial begin
        forever #4 clock = ~clock;
    end

    function logic [7:0] rnd();
        rng = {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
        return rng[7:0];
    endfunction : rnd
    function logic [7:0] mem(input logic [7:0] a);
        return a ^ 8'ha5;
    endfunction : mem
    function logic [15:0] sx(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : sx

    task chk(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : chk

    task stop_test;
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    // fl: jump check, y used, illegal
    task go(input logic [7:0] b0, b1, b2, b3, input int n, input amode_t m,
            input logic [15:0] ea, off, input logic [2:0] fl, input inh_op_t inh = I_NONE);
        logic [7:0] b [4];
        logic pf;
        int k;
        b = '{b0, b1, b2, b3};
        pf = b0 inside {8'h90, 8'h91, 8'h92};
        q.push_back('{m, 3'(n), ea, pc + 16'(n) + off, fl, inh, pf ? b1 : b0, pf ? b2 : b1});
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge clock);
            while (byte_ready !== 1'b1) begin
                byte_valid = 1'b1;
                byte_data = rnd();
                k++;
                if (k > 60) begin
                    errors++;
                    stop_test();
                end
                @(negedge clock);
            end
            byte_valid = 1'b1;
            byte_data = b[i];
            fetch_pc = pc + 16'(i);
            if (i == 0) begin
                x_reg = x;
                y_reg = y;
                lat = 2'(rnd());
            end
        end
    endtask : go

    always @(negedge clock) begin
        exp_t e;
        if (dec_valid === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
                $display("unexpected at %0t: stray result", $time);
            end else begin
                e = q.pop_front();
                chk(16'(mode), 16'(e.m));
                chk(16'(length), 16'(e.len));
                chk(eff_addr, e.ea);
                chk(16'(inh_op), 16'(e.inh));
                chk(16'(illegal), 16'(e.fl[0]));
                chk(16'(opcode), 16'(e.op));
                chk(16'(bit_num), 16'(e.op[3:1]));
                if (e.fl[2]) chk(jump_target, e.jt);
                if (!e.fl[0]) chk(16'(use_y), 16'(e.fl[1]));
                if (e.m == M_IMMEDIATE) chk(16'(operand), 16'(e.opnd));
            end
        end
    end

    initial begin
        #400000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        chk(16'(byte_ready), 16'h0);
        srst = 1'b0;
        repeat (2) @(negedge clock);
        for (int it = 0; it < 6; it++) begin
            x = rnd();
            y = rnd();
            o = rnd();
            h = rnd();
            p = rnd();
            pc = {rnd(), rnd()};
            if (it == 0) begin
                x = 8'hff;
                y = 8'hff;
                o = 8'hff;
                p = 8'hff;
            end
            if (it == 1) o = 8'h80;
            if (it == 2) o = 8'h7f;
            if (it == 0) for (int i = 0; i < 15; i++)
                go(iops[i], '0, '0, '0, 1, M_INHERENT, '0, '0, '0, iexp[i]);
            go(8'ha6, o, '0, '0, 2, M_IMMEDIATE, '0, '0, '0);
            go(8'hb6, o, '0, '0, 2, M_DIR_SHORT, {8'h00, o}, '0, '0);
            go(8'hc6, h, o, '0, 3, M_DIR_LONG, {h, o}, '0, '0);
            go(8'hf6, '0, '0, '0, 1, M_IDX_NONE, {8'h00, x}, '0, '0);
            go(8'h90, 8'hf6, '0, '0, 2, M_IDX_NONE, {8'h00, y}, '0, 3'h2);
            go(8'he6, o, '0, '0, 2, M_IDX_SHORT, {8'h00, o} + x, '0, '0);
            go(8'hd6, h, o, '0, 3, M_IDX_LONG, {h, o} + x, '0, '0);
            go(8'h92, 8'hb6, p, '0, 3, M_IND_SHORT, {8'h00, mem(p)}, '0, '0);
            go(8'h92, 8'hc6, p, '0, 3, M_IND_LONG, {mem(p), mem(p + 8'h1)}, '0, '0);
            go(8'h92, 8'he6, p, '0, 3, M_IND_IDX_SHORT, {8'h00, mem(p)} + x, '0, '0);
            go(8'h91, 8'he6, p, '0, 3, M_IND_IDX_SHORT, {8'h00, mem(p)} + y, '0, 3'h2);
            go(8'h92, 8'hd6, p, '0, 3, M_IND_IDX_LONG, {mem(p), mem(p + 8'h1)} + x, '0,
                '0);
            go(8'h27, o, '0, '0, 2, M_REL_DIRECT, '0, sx(o), 3'h4);
            go(8'h92, 8'h27, p, '0, 3, M_REL_INDIRECT, '0, sx(mem(p)), 3'h4);
            go({4'h1, o[2:0], 1'b0}, p, '0, '0, 2, M_BIT_DIRECT, {8'h00, p}, '0, '0);
            go(8'h92, 8'h1e, p, '0, 3, M_BIT_INDIRECT, {8'h00, mem(p)}, '0, '0);
            go(8'h0e, p, o, '0, 3, M_BIT_DIR_REL, {8'h00, p}, sx(o), 3'h4);
            go(8'h92, 8'h0e, p, o, 4, M_BIT_IND_REL, {8'h00, mem(p)}, sx(o), 3'h4);
            go(8'h90, 8'h27, o, '0, 3, M_REL_DIRECT, '0, sx(o), 3'h5);
        end
        @(negedge clock);
        byte_valid = 1'b0;
        repeat (40) @(negedge clock);
        chk(16'(q.size()), 16'h0);
        stop_test();
    end
endmodule : cpu_addressing_mode_decoder_bench
